// ---- design/uder_pkg.sv ----
`default_nettype none
package uder_pkg;
	localparam int NEP  = 7;
	localparam int BC_W = 11;
	// register offsets
	localparam logic [3:0] A_SELECT  = 4'h0;
	localparam logic [3:0] A_TYPEDIR = 4'h1;
	localparam logic [3:0] A_SIZEBK  = 4'h2;
	localparam logic [3:0] A_STAT0   = 4'h3;
	localparam logic [3:0] A_STAT1   = 4'h4;
	localparam logic [3:0] A_FLAGS   = 4'h5;
	localparam logic [3:0] A_ENABLES = 4'h6;
	localparam logic [3:0] A_DATA    = 4'h7;
	localparam logic [3:0] A_BC_HIGH = 4'h8;
	localparam logic [3:0] A_BC_LOW  = 4'h9;
	localparam logic [3:0] A_SUMMARY = 4'ha;
	// encodings
	localparam logic [1:0] K_CONTROL = 2'h0;
	localparam logic [1:0] K_ISO     = 2'h1;
	localparam logic [1:0] K_BULK    = 2'h2;
	localparam logic [1:0] K_INTR    = 2'h3;
	localparam logic [2:0] SIZE_MAX  = 3'h6;
	localparam logic [1:0] BANK_MAX  = 2'h1;
	localparam logic [2:0] SEL_BAD   = 3'h7;
	localparam logic [BC_W-1:0] SIZE_MIN = 11'h008;
	// event flag and enable bit positions, flag and enable masks
	localparam int FB_FIFO_CONTROL = 7;
	localparam int FB_NAK_IN       = 6;
	localparam int FB_ACCESS       = 5;
	localparam int FB_NAK_OUT      = 4;
	localparam int FB_SETUP        = 3;
	localparam int FB_OUT          = 2;
	localparam int FB_STALL        = 1;
	localparam int FB_TX_READY     = 0;
	localparam int EB_FLOW_ERR     = 7;
	localparam logic [7:0] SW_CLEARABLE = 8'hdf;
	localparam logic [7:0] IRQ_SOURCES  = 8'h5f;
	localparam logic [7:0] ENABLE_MASK  = 8'hdf;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} uder_req_t;

	typedef struct packed {
		logic [2:0] ep;
		logic       setup_stored;
		logic       out_stored;
		logic       in_sent;
		logic       nak_in;
		logic       nak_out;
		logic       stall_sent;
		logic       crc_err;
		logic       overflow;
		logic       underflow;
		logic       rx_valid;
		logic [7:0] rx_byte;
		logic       tx_take;
		logic       toggle;
		logic       ctrl_dir;
	} uder_ev_t;

	typedef struct packed {
		logic [1:0]           endpoint_kind;
		logic                 endpoint_in_dir;
		logic [2:0]           endpoint_size_code;
		logic [1:0]           bank_count_code;
		logic                 memory_reserve;
		logic                 config_valid;
		logic                 iso_overflow_flag;
		logic                 iso_underflow_flag;
		logic                 toggle_status;
		logic [1:0]           busy_bank_count;
		logic                 control_next_dir;
		logic                 current_bank_index;
		logic                 usb_bank;
		logic                 discard_bank;
		logic [7:0]           flags;
		logic [7:0]           enables;
		logic [1:0][BC_W-1:0] count;
		logic [BC_W-1:0]      cpu_ptr;
		logic [BC_W-1:0]      usb_ptr;
	} uder_ep_t;

	typedef struct packed {
		logic [2:0]            endpoint_select;
		uder_ep_t [NEP-1:0]    ep;
		logic [7:0]            rdata;
		logic [7:0]            tx_byte;
		logic [NEP-1:0]        endpoint_irq_vector;
		logic                  endpoint_irq;
	} uder_state_t;
endpackage
`default_nettype wire

// ---- design/uder_endpoint_regs.sv ----
`default_nettype none
// Contract
// - type field picks control, iso, bulk, interrupt
// - direction bit one means IN, control always OUT
// - size codes 8 to 512 bytes, 111b reserved
// - bank code one or double, 1xb reserved
// - reserve bit allocates, clearing frees memory
// - config valid only when size and banks fit
// - iso overflow/underflow set by hardware, clear-only
// - toggle status reports DATA0 or DATA1
// - busy bank count 0, 1 or 2
// - control direction and current bank, read-only
// - OUT/SETUP stored sets fifo control, clear frees
// - IN bank free sets fifo control, clear commits
// - NAK IN and NAK OUT flags, clear-only
// - access allowed when bank usable, not stalled
// - SETUP flag set on new setup, not IN
// - OUT flag set on new packet, clear-only
// - IN discard request kills last bank, self-clears
// - stall flag on STALL sent or iso OUT CRC
// - transmit ready when IN bank free, not OUT
// - enables gate flags, flow enable covers both
// - data register moves bytes, count tracks them
// - summary vector bit per endpoint with enabled flag
// - select picks endpoint, 111b forbidden
module uder_endpoint_regs #(
	parameter int BANK_DEPTH = 512
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// register port
	input  wire uder_pkg::uder_req_t req,
	output logic [7:0]               rdata,
	// usb transaction engine
	input  wire uder_pkg::uder_ev_t  ev,
	input  wire logic [6:0]          stall_request,
	input  wire logic [6:0]          ep_error,
	output logic [7:0]               tx_byte,
	output logic [6:0]               in_ready,
	output logic [6:0]               out_space,
	// cpu interrupt
	output logic                     endpoint_irq
);
	import uder_pkg::*;

	localparam int AW = $clog2(BANK_DEPTH);
	localparam int MW = 4 + AW;

	uder_state_t s;
	uder_state_t next_s;
	logic [7:0]  mem [0:(1 << MW)-1];
	logic          cpu_we;
	logic          usb_we;
	logic [MW-1:0] cpu_addr;
	logic [MW-1:0] usb_addr;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_in_ep(uder_ep_t x);
		return x.endpoint_in_dir && (x.endpoint_kind != K_CONTROL);
	endfunction

	function automatic logic [1:0] banks_of(uder_ep_t x);
		return (x.bank_count_code == BANK_MAX) ? 2'h2 : 2'h1;
	endfunction

	function automatic logic [BC_W-1:0] bytes_of(uder_ep_t x);
		return SIZE_MIN << x.endpoint_size_code;
	endfunction

	function automatic logic access_ok(uder_ep_t x, logic stl, logic err);
		logic ok;
		ok = 1'b0;
		if (is_in_ep(x)) begin
			ok = (x.busy_bank_count < banks_of(x))
				&& (x.count[x.current_bank_index] < bytes_of(x));
		end else begin
			ok = (x.busy_bank_count != 2'h0)
				&& (x.count[x.current_bank_index] != '0);
		end
		return ok && x.memory_reserve && !stl && !err;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		uder_ep_t   c;
		uder_ep_t   n;
		logic       in_ep;
		logic       iso;
		logic       sel;
		logic       hit;
		logic       inc;
		logic       dec;
		logic       fit;
		logic [1:0] nb;
		logic [7:0] fl;
		logic [7:0] rd;
		next_s = s;
		cpu_we = 1'b0;
		usb_we = 1'b0;
		c = s.ep[0];
		n = c;
		in_ep = 1'b0;
		iso = 1'b0;
		sel = 1'b0;
		hit = 1'b0;
		inc = 1'b0;
		dec = 1'b0;
		fit = 1'b0;
		nb = 2'h1;
		fl = 8'h00;
		rd = 8'h00;
		cpu_addr = {s.endpoint_select, 1'b0, {AW{1'b0}}};
		usb_addr = {ev.ep, 1'b0, {AW{1'b0}}};
		if (req.wr && req.addr == A_SELECT && req.wdata[2:0] != SEL_BAD) begin
			next_s.endpoint_select = req.wdata[2:0];
		end
		for (int e = 0; e < NEP; e++) begin
			c = s.ep[e];
			n = c;
			in_ep = is_in_ep(c);
			iso = (c.endpoint_kind == K_ISO);
			nb = banks_of(c);
			sel = (s.endpoint_select == 3'(e));
			hit = (ev.ep == 3'(e));
			inc = 1'b0;
			dec = 1'b0;
			// cpu side
			if (sel && req.wr) begin
				unique case (req.addr)
					A_TYPEDIR: begin
						n.endpoint_kind = req.wdata[7:6];
						n.endpoint_in_dir = req.wdata[0];
					end
					A_SIZEBK: begin
						n.endpoint_size_code = req.wdata[6:4];
						n.bank_count_code = req.wdata[3:2];
						n.memory_reserve = req.wdata[1];
						fit = (req.wdata[6:4] <= SIZE_MAX) && (req.wdata[3:2] <= BANK_MAX)
							&& ((SIZE_MIN << req.wdata[6:4]) <= BC_W'(BANK_DEPTH));
						n.config_valid = req.wdata[1] && fit;
						n.busy_bank_count = 2'h0;
						n.current_bank_index = 1'b0;
						n.usb_bank = 1'b0;
						n.count = '0;
						n.cpu_ptr = '0;
						n.usb_ptr = '0;
						n.flags = 8'h00;
						if (n.config_valid && in_ep) begin
							n.flags[FB_FIFO_CONTROL] = 1'b1;
							n.flags[FB_TX_READY] = 1'b1;
						end
					end
					A_STAT0: begin
						n.iso_overflow_flag = c.iso_overflow_flag & req.wdata[6];
						n.iso_underflow_flag = c.iso_underflow_flag & req.wdata[5];
					end
					A_FLAGS: begin
						n.flags = c.flags & (req.wdata | ~SW_CLEARABLE);
						if (in_ep && req.wdata[FB_OUT]) begin
							n.discard_bank = 1'b1;
						end
						if (c.flags[FB_FIFO_CONTROL] && !req.wdata[FB_FIFO_CONTROL]) begin
							n.cpu_ptr = '0;
							n.current_bank_index = (nb == 2'h2) ? !c.current_bank_index
								: c.current_bank_index;
							if (in_ep) begin
								inc = 1'b1;
							end else begin
								dec = 1'b1;
								n.count[c.current_bank_index] = '0;
							end
						end
					end
					A_ENABLES: n.enables = req.wdata & ENABLE_MASK;
					A_DATA: begin
						if (in_ep && access_ok(c, stall_request[e], ep_error[e])) begin
							cpu_we = 1'b1;
							n.count[c.current_bank_index] = c.count[c.current_bank_index] + 1'b1;
							n.cpu_ptr = c.cpu_ptr + 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			if (sel && req.rd && req.addr == A_DATA && !in_ep
				&& c.count[c.current_bank_index] != '0) begin
				n.count[c.current_bank_index] = c.count[c.current_bank_index] - 1'b1;
				n.cpu_ptr = c.cpu_ptr + 1'b1;
			end
			if (sel) begin
				cpu_addr = {3'(e), c.current_bank_index, c.cpu_ptr[AW-1:0]};
			end
			// pending discard of the last committed IN bank
			if (c.discard_bank) begin
				n.discard_bank = 1'b0;
				if (c.busy_bank_count != 2'h0) begin
					dec = 1'b1;
					n.current_bank_index = (nb == 2'h2) ? !c.current_bank_index
						: c.current_bank_index;
					n.count[n.current_bank_index] = '0;
					n.cpu_ptr = '0;
				end
			end
			// usb side, events set after software clears
			if (hit) begin
				if (ev.rx_valid && !in_ep) begin
					usb_we = 1'b1;
					n.count[c.usb_bank] = n.count[c.usb_bank] + 1'b1;
					n.usb_ptr = c.usb_ptr + 1'b1;
				end
				if (ev.tx_take && in_ep && c.count[c.usb_bank] != '0) begin
					n.count[c.usb_bank] = n.count[c.usb_bank] - 1'b1;
					n.usb_ptr = c.usb_ptr + 1'b1;
				end
				if ((ev.out_stored || ev.setup_stored) && !in_ep) begin
					inc = 1'b1;
					n.usb_ptr = '0;
					n.toggle_status = ev.toggle;
					n.usb_bank = (nb == 2'h2) ? !c.usb_bank : c.usb_bank;
				end
				if (ev.setup_stored && !in_ep) begin
					n.control_next_dir = ev.ctrl_dir;
				end
				if (ev.in_sent && in_ep && c.busy_bank_count != 2'h0) begin
					dec = 1'b1;
					n.usb_ptr = '0;
					n.toggle_status = ev.toggle;
					n.usb_bank = (nb == 2'h2) ? !c.usb_bank : c.usb_bank;
				end
				if (ev.nak_in) begin
					n.flags[FB_NAK_IN] = 1'b1;
				end
				if (ev.nak_out) begin
					n.flags[FB_NAK_OUT] = 1'b1;
				end
				if (ev.stall_sent || (ev.crc_err && iso && !in_ep)) begin
					n.flags[FB_STALL] = 1'b1;
				end
				if (ev.overflow && iso) begin
					n.iso_overflow_flag = 1'b1;
				end
				if (ev.underflow && iso) begin
					n.iso_underflow_flag = 1'b1;
				end
			end
			n.busy_bank_count = n.busy_bank_count + {1'b0, inc} - {1'b0, dec};
			// a bank arriving at the cpu side raises the handshake bits
			if (!in_ep && c.memory_reserve) begin
				if ((c.busy_bank_count == 2'h0 && inc && !dec)
					|| (dec && c.busy_bank_count == 2'h2)) begin
					n.flags[FB_FIFO_CONTROL] = 1'b1;
					if (hit && ev.setup_stored && c.busy_bank_count == 2'h0) begin
						n.flags[FB_SETUP] = 1'b1;
					end else begin
						n.flags[FB_OUT] = 1'b1;
					end
				end
			end
			if (in_ep && c.memory_reserve && (dec || c.discard_bank)
				&& (c.busy_bank_count == nb) && !(sel && req.wr && req.addr == A_SIZEBK)) begin
				n.flags[FB_FIFO_CONTROL] = 1'b1;
				n.flags[FB_TX_READY] = 1'b1;
			end
			if (in_ep && inc && n.busy_bank_count < nb) begin
				n.flags[FB_FIFO_CONTROL] = 1'b1;
				n.flags[FB_TX_READY] = 1'b1;
			end
			if (in_ep) begin
				n.flags[FB_SETUP] = 1'b0;
				n.flags[FB_OUT] = 1'b0;
			end else begin
				n.flags[FB_TX_READY] = 1'b0;
			end
			n.flags[FB_ACCESS] = 1'b0;
			fl = c.flags & IRQ_SOURCES & c.enables;
			next_s.endpoint_irq_vector[e] = (|fl) || (c.enables[EB_FLOW_ERR]
				&& (c.iso_overflow_flag || c.iso_underflow_flag));
			next_s.ep[e] = n;
		end
		if (ev.ep != SEL_BAD) begin
			c = s.ep[ev.ep];
			usb_addr = {ev.ep, c.usb_bank, c.usb_ptr[AW-1:0]};
			if (ev.tx_take) begin
				next_s.tx_byte = mem[usb_addr];
			end
		end
		next_s.endpoint_irq = |s.endpoint_irq_vector;
		// read answer, one cycle after the strobe
		c = s.ep[s.endpoint_select];
		rd = 8'h00;
		unique case (req.addr)
			A_SELECT:  rd = {5'h00, s.endpoint_select};
			A_TYPEDIR: rd = {c.endpoint_kind, 5'h00, c.endpoint_in_dir};
			A_SIZEBK:  rd = {1'b0, c.endpoint_size_code, c.bank_count_code,
				c.memory_reserve, 1'b0};
			A_STAT0:   rd = {c.config_valid, c.iso_overflow_flag, c.iso_underflow_flag,
				2'h0, c.toggle_status, c.busy_bank_count};
			A_STAT1:   rd = {5'h00, c.control_next_dir, 1'b0,
				c.current_bank_index && c.endpoint_kind != K_CONTROL};
			A_FLAGS: begin
				rd = c.flags;
				rd[FB_ACCESS] = access_ok(c, stall_request[s.endpoint_select],
					ep_error[s.endpoint_select]);
				if (is_in_ep(c)) begin
					rd[FB_OUT] = c.discard_bank;
				end
			end
			A_ENABLES: rd = c.enables;
			A_DATA:    rd = mem[cpu_addr];
			A_BC_HIGH: rd = {5'h00, c.count[c.current_bank_index][BC_W-1:8]};
			A_BC_LOW:  rd = c.count[c.current_bank_index][7:0];
			A_SUMMARY: rd = {1'b0, s.endpoint_irq_vector};
			default:   rd = 8'h00;
		endcase
		next_s.rdata = req.rd ? rd : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// registers and fifo memory

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge clk) begin
		if (cpu_we) begin
			mem[cpu_addr] <= req.wdata;
		end
		if (usb_we) begin
			mem[usb_addr] <= ev.rx_byte;
		end
	end

	always_comb begin
		for (int e = 0; e < NEP; e++) begin
			in_ready[e] = is_in_ep(s.ep[e]) && s.ep[e].busy_bank_count != 2'h0;
			out_space[e] = !is_in_ep(s.ep[e]) && s.ep[e].memory_reserve
				&& s.ep[e].busy_bank_count < banks_of(s.ep[e]);
		end
	end

	assign rdata = s.rdata;
	assign tx_byte = s.tx_byte;
	assign endpoint_irq = s.endpoint_irq;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_select_legal: assert property (@(posedge clk) disable iff (!rst_n)
		s.endpoint_select != SEL_BAD) else $error("forbidden endpoint selected");

	a_size_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == A_SIZEBK && req.wdata[6:4] == 3'h7
		|=> !s.ep[$past(s.endpoint_select)].config_valid)
		else $error("reserved size accepted");

	a_bank_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == A_SIZEBK && req.wdata[3]
		|=> !s.ep[$past(s.endpoint_select)].config_valid)
		else $error("reserved bank code accepted");

	a_ovf_clear_only: assert property (@(posedge clk) disable iff (!rst_n)
		!s.ep[s.endpoint_select].iso_overflow_flag && !ev.overflow
		&& req.wr && req.addr == A_STAT0
		|=> !s.ep[$past(s.endpoint_select)].iso_overflow_flag)
		else $error("overflow flag set by software");

	a_out_flag_w1: assert property (@(posedge clk) disable iff (!rst_n)
		!s.ep[s.endpoint_select].flags[FB_OUT] && req.wr && req.addr == A_FLAGS
		&& !s.ep[s.endpoint_select].endpoint_in_dir && ev.ep != s.endpoint_select
		&& (req.wdata[FB_FIFO_CONTROL] || !s.ep[s.endpoint_select].flags[FB_FIFO_CONTROL])
		|=> !s.ep[$past(s.endpoint_select)].flags[FB_OUT])
		else $error("out flag set by software");

	a_discard_clears: assert property (@(posedge clk) disable iff (!rst_n)
		s.ep[s.endpoint_select].discard_bank
		|=> !s.ep[$past(s.endpoint_select)].discard_bank)
		else $error("discard request never cleared");

	a_busy_range: assert property (@(posedge clk) disable iff (!rst_n)
		s.ep[s.endpoint_select].busy_bank_count != 2'h3)
		else $error("busy bank count out of range");

	a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
		(s.endpoint_irq_vector != 7'h00) |=> endpoint_irq)
		else $error("interrupt missing for summary bit");

	a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!req.rd |=> rdata == 8'h00) else $error("read data without read strobe");
endmodule
`default_nettype wire

// ---- verif/uder_host_model.sv ----
`default_nettype none
module uder_host_model (
	// clock
	input  wire logic          clk,
	// transaction events toward the endpoint block
	output uder_pkg::uder_ev_t ev
);
	timeunit 1ns;
	timeprecision 1ps;
	import uder_pkg::*;

	initial ev = '0;

	////////////////////////////////////////////////////////////////////////////////
	// one-cycle strobe; the byte lane then shows the inverse of its last value
	task automatic pulse(input uder_ev_t e, input int gap);
		uder_ev_t idle;
		idle = '0;
		idle.rx_byte = ~e.rx_byte;
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= idle;
		repeat (gap) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// bytes base*1, base*2 ... first, then the stored strobe
	task automatic packet(input logic [2:0] ep, input logic setup, input logic tgl,
		input logic dir, input int n, input logic [7:0] base, input int gap);
		uder_ev_t e;
		for (int i = 0; i < n; i++) begin
			e = '0;
			e.ep = ep;
			e.rx_valid = 1'b1;
			e.rx_byte = 8'(base * (i + 1));
			pulse(e, gap);
		end
		e = '0;
		e.ep = ep;
		e.toggle = tgl;
		e.ctrl_dir = dir;
		e.setup_stored = setup;
		e.out_stored = ~setup;
		pulse(e, gap);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// k: nak_in 01, nak_out 02, stall 04, crc 08, ovf 10, udf 20, take 40, sent 80
	task automatic strike(input logic [2:0] ep, input logic [7:0] k);
		uder_ev_t e;
		e = '0;
		e.ep = ep;
		{e.in_sent, e.tx_take, e.underflow, e.overflow} = k[7:4];
		{e.crc_err, e.stall_sent, e.nak_out, e.nak_in} = k[3:0];
		pulse(e, 0);
	endtask
endmodule
`default_nettype wire

// ---- verif/uder_endpoint_regs_tb_top.sv ----
`default_nettype none
module uder_endpoint_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uder_pkg::*;

	logic       clk;
	logic       rst_n;
	uder_req_t  req;
	uder_ev_t   ev;
	logic [7:0] rdata;
	logic [7:0] tx_byte;
	logic [6:0] stall_request;
	logic [6:0] ep_error;
	logic [6:0] in_ready;
	logic [6:0] out_space;
	logic       endpoint_irq;
	int         miscompares;
	int         n_compared;
	int         cycles;
	logic [7:0] cfg_w [4] = '{8'h72, 8'h42, 8'h3a, 8'h36};

	uder_endpoint_regs #(.BANK_DEPTH(64)) i_uder_endpoint_regs (
		.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .ev(ev),
		.stall_request(stall_request), .ep_error(ep_error), .tx_byte(tx_byte),
		.in_ready(in_ready), .out_space(out_space), .endpoint_irq(endpoint_irq));
	uder_host_model i_uder_host_model (.clk(clk), .ev(ev));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read, mask and compare; data stand only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		rst_n = 1'b0;
		req = '0;
		stall_request = '0;
		ep_error = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rc(A_STAT0, 8'hff, 8'h00);
		rc(A_FLAGS, 8'hff, 8'h00);
		rc(A_ENABLES, 8'hff, 8'h00);
		wr(A_ENABLES, 8'hff);
		rc(A_ENABLES, 8'hff, 8'hdf);
		wr(4'hb, 8'hff);
		rc(4'hb, 8'hff, 8'h00);
		wr(A_SELECT, 8'h01);
		wr(A_SELECT, 8'h07);
		rc(A_SELECT, 8'hff, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(A_TYPEDIR, {2'(k), 6'h01});
			rc(A_TYPEDIR, 8'hff, {2'(k), 6'h01});
		end
		wr(A_TYPEDIR, 8'h80);
		for (int k = 0; k < 4; k++) begin
			wr(A_SIZEBK, cfg_w[k]);
			rc(A_STAT0, 8'h80, (k == 3) ? 8'h80 : 8'h00);
		end
		rc(A_SIZEBK, 8'hff, 8'h36);
		chk({7'h0, out_space[1]}, 8'h01);
		// bulk OUT on endpoint 1, slow host
		wr(A_ENABLES, 8'h04);
		i_uder_host_model.packet(3'h1, 1'b0, 1'b1, 1'b0, 3, 8'h11, 2);
		rc(A_FLAGS, 8'hff, 8'ha4);
		rc(A_STAT0, 8'hff, 8'h85);
		rc(A_BC_LOW, 8'hff, 8'h03);
		rc(A_BC_HIGH, 8'hff, 8'h00);
		rc(A_SUMMARY, 8'hff, 8'h02);
		chk({7'h0, endpoint_irq}, 8'h01);
		@(posedge clk) stall_request <= 7'h02;
		rc(A_FLAGS, 8'h20, 8'h00);
		@(posedge clk) stall_request <= 7'h00;
		wr(A_FLAGS, 8'hfb);
		rc(A_FLAGS, 8'hff, 8'ha0);
		rc(A_SUMMARY, 8'hff, 8'h00);
		chk({7'h0, endpoint_irq}, 8'h00);
		wr(A_FLAGS, 8'h84);
		rc(A_FLAGS, 8'h04, 8'h00);
		for (int k = 1; k < 4; k++)
			rc(A_DATA, 8'hff, 8'(k * 17));
		rc(A_BC_LOW, 8'hff, 8'h00);
		rc(A_FLAGS, 8'ha0, 8'h80);
		wr(A_FLAGS, 8'h7f);
		rc(A_STAT0, 8'h03, 8'h00);
		rc(A_STAT1, 8'h03, 8'h01);
		i_uder_host_model.packet(3'h1, 1'b0, 1'b0, 1'b0, 1, 8'h44, 0);
		i_uder_host_model.packet(3'h1, 1'b0, 1'b1, 1'b0, 1, 8'h55, 0);
		rc(A_STAT0, 8'h03, 8'h02);
		chk({7'h0, out_space[1]}, 8'h00);
		// control endpoint 0: setup, naks, stall
		wr(A_SELECT, 8'h00);
		wr(A_TYPEDIR, 8'h00);
		wr(A_SIZEBK, 8'h02);
		i_uder_host_model.packet(3'h0, 1'b1, 1'b0, 1'b1, 8, 8'h01, 0);
		rc(A_FLAGS, 8'hdf, 8'h88);
		rc(A_STAT1, 8'h04, 8'h04);
		wr(A_FLAGS, 8'h00);
		rc(A_FLAGS, 8'hdf, 8'h00);
		i_uder_host_model.strike(3'h0, 8'h01);
		i_uder_host_model.strike(3'h0, 8'h02);
		i_uder_host_model.strike(3'h0, 8'h04);
		rc(A_FLAGS, 8'h52, 8'h52);
		wr(A_ENABLES, 8'h02);
		rc(A_SUMMARY, 8'h01, 8'h01);
		wr(A_ENABLES, 8'h00);
		rc(A_SUMMARY, 8'h01, 8'h00);
		wr(A_FLAGS, 8'hff);
		rc(A_FLAGS, 8'h52, 8'h52);
		wr(A_FLAGS, 8'h00);
		rc(A_FLAGS, 8'h52, 8'h00);
		// isochronous IN on endpoint 2
		wr(A_SELECT, 8'h02);
		wr(A_TYPEDIR, 8'h41);
		wr(A_SIZEBK, 8'h02);
		rc(A_FLAGS, 8'hff, 8'ha1);
		@(posedge clk) ep_error <= 7'h04;
		rc(A_FLAGS, 8'h20, 8'h00);
		@(posedge clk) ep_error <= 7'h00;
		i_uder_host_model.strike(3'h2, 8'h10);
		i_uder_host_model.strike(3'h2, 8'h20);
		rc(A_STAT0, 8'h60, 8'h60);
		wr(A_STAT0, 8'h60);
		rc(A_STAT0, 8'h60, 8'h60);
		wr(A_ENABLES, 8'h80);
		rc(A_SUMMARY, 8'h04, 8'h04);
		wr(A_STAT0, 8'h00);
		rc(A_STAT0, 8'h60, 8'h00);
		wr(A_STAT0, 8'h60);
		rc(A_STAT0, 8'h60, 8'h00);
		i_uder_host_model.strike(3'h2, 8'h08);
		rc(A_FLAGS, 8'h02, 8'h00);
		wr(A_DATA, 8'ha5);
		wr(A_DATA, 8'h5a);
		rc(A_BC_LOW, 8'hff, 8'h02);
		wr(A_FLAGS, 8'h00);
		rc(A_STAT0, 8'h03, 8'h01);
		chk({7'h0, in_ready[2]}, 8'h01);
		i_uder_host_model.strike(3'h2, 8'h40);
		#1;
		chk(tx_byte, 8'ha5);
		i_uder_host_model.strike(3'h2, 8'h40);
		#1;
		chk(tx_byte, 8'h5a);
		rc(A_BC_LOW, 8'hff, 8'h00);
		i_uder_host_model.strike(3'h2, 8'h80);
		rc(A_STAT0, 8'h03, 8'h00);
		rc(A_FLAGS, 8'h81, 8'h81);
		// commit one byte, then discard it
		wr(A_DATA, 8'h3c);
		wr(A_FLAGS, 8'h00);
		rc(A_STAT0, 8'h03, 8'h01);
		wr(A_FLAGS, 8'h84);
		rc(A_STAT0, 8'h03, 8'h00);
		rc(A_FLAGS, 8'h04, 8'h00);
		chk({7'h0, in_ready[2]}, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
